// ==== inc/mbw_pkg.sv ====
// Purpose: Shared constants and types for the boot and runtime watchdog
// Assumes: 250 MHz core clock, all timeouts in whole seconds
// Notes:   Selector codes match the order of the configuration options

package mbw_pkg;

  // ************************************************************
  // Timing base
  // ************************************************************
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned SEC_PS = 1000000000;
  localparam int unsigned SEC_TO_PS_DIV = 1000;
  // Cycles per second, derived from the clock period
  localparam int unsigned CYC_PER_SEC = (SEC_PS / CLK_PERIOD_PS) * SEC_TO_PS_DIV;

  // Seconds counter width, enough for 30 minutes
  localparam int unsigned SEC_W = 11;
  typedef logic [SEC_W-1:0] mbw_sec_t;

  // ************************************************************
  // Timeouts in seconds
  // ************************************************************
  localparam mbw_sec_t T_0S = 11'h000;
  localparam mbw_sec_t T_1S = 11'h001;
  localparam mbw_sec_t T_2S = 11'h002;
  localparam mbw_sec_t T_5S = 11'h005;
  localparam mbw_sec_t T_10S = 11'h00a;
  localparam mbw_sec_t T_30S = 11'h01e;
  localparam mbw_sec_t T_1M = 11'h03c;
  localparam mbw_sec_t T_2M = 11'h078;
  localparam mbw_sec_t T_5M = 11'h12c;
  localparam mbw_sec_t T_10M = 11'h258;
  localparam mbw_sec_t T_30M = 11'h708;

  // ************************************************************
  // Selector encodings
  // ************************************************************
  // Boot watchdog: 0 off, 1 30s, 2 1m, 3 2m, 4 5m, 5 10m, 6+ 30m
  localparam logic [2:0] POST_OFF = 3'h0;
  // Start delay: 0 off, 1 10s, 2 30s, 3 1m, 4 2m, 5 5m, 6 10m, 7 30m
  localparam logic [2:0] DLY_OFF = 3'h0;
  // Stage timeout: 0 1s .. 9 30m, others fall back to 30s
  localparam logic [3:0] TO_DEFAULT = 4'h4;

  // Runtime operating modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ONCE = 2'h1;
  localparam logic [1:0] MODE_SINGLE = 2'h2;
  localparam logic [1:0] MODE_REPEAT = 2'h3;

  // Stage actions
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_ACPI = 2'h1;
  localparam logic [1:0] ACT_RESET = 2'h2;
  localparam logic [1:0] ACT_PWRBTN = 2'h3;

  // Stage indices
  localparam logic [1:0] STG_1 = 2'h0;
  localparam logic [1:0] STG_2 = 2'h1;
  localparam logic [1:0] STG_3 = 2'h2;

  // Number of synchronised pin inputs
  localparam int unsigned N_PINS = 4;

  // Runtime state machine
  typedef enum logic [1:0] {
    RT_OFF,
    RT_DELAY,
    RT_STAGE,
    RT_DONE
  } mbw_rt_e;

endpackage

// ==== inc/mbw_tmr_if.sv ====
// Purpose: Control and expiry bundle between watchdog logic and a timer
// Assumes: One controller and one timer per instance
// Notes:   Expiry is a one-cycle pulse

`timescale 1ns/1ps

interface mbw_tmr_if;
  logic load;
  mbw_pkg::mbw_sec_t load_val;
  logic run;
  logic expire;

  modport ctl (output load, output load_val, output run, input expire);
  modport tmr (input load, input load_val, input run, output expire);
endinterface

// ==== hw/mbw_in_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter per bit
// Assumes: Inputs asynchronous to i_clk
// Notes:   Output changes only when stages two and three agree

`timescale 1ns/1ps

module mbw_in_sync #(
  parameter int unsigned W = 4
) (
  input wire logic i_clk,          // Core clock
  input wire logic i_rstn,         // Sync reset, active low
  input wire logic [W-1:0] i_d,    // Asynchronous inputs
  output logic [W-1:0] o_q         // Filtered levels
);

  // ************************************************************
  // Per-bit chain
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;

      // First stage feeds only the second one
      always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= i_d[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end

      // Accept a change once it is stable
      always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
          lvl_q <= 1'b0;
        end else if (s2_q == s3_q) begin
          lvl_q <= s3_q;
        end
      end

      assign o_q[gi] = lvl_q;
    end
  endgenerate

endmodule

// ==== hw/mbw_timer.sv ====
// Purpose: Seconds countdown timer with its own cycle prescaler
// Assumes: Load value in whole seconds, zero means idle
// Notes:   Load restarts the prescaler so timeouts are exact

`timescale 1ns/1ps

module mbw_timer #(
  parameter int unsigned P_CYC_PER_SEC = mbw_pkg::CYC_PER_SEC
) (
  input wire logic i_clk,          // Core clock
  input wire logic i_rstn,         // Sync reset, active low
  mbw_tmr_if.tmr t                 // Control and expiry
);

  localparam int unsigned CW = (P_CYC_PER_SEC > 1) ? $clog2(P_CYC_PER_SEC) : 1;
  localparam logic [CW-1:0] CYC_LAST = CW'(P_CYC_PER_SEC - 1);

  logic [CW-1:0] cyc_q;
  mbw_pkg::mbw_sec_t sec_q;

  // ************************************************************
  // Count down
  // ************************************************************
  // Pausing keeps both counts, so a halted timer resumes where it was
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cyc_q <= '0;
      sec_q <= '0;
      t.expire <= 1'b0;
    end else if (t.load) begin
      cyc_q <= '0;
      sec_q <= t.load_val;
      t.expire <= 1'b0;
    end else begin
      t.expire <= 1'b0;
      if (t.run && (sec_q != '0)) begin
        if (cyc_q == CYC_LAST) begin
          cyc_q <= '0;
          sec_q <= sec_q - mbw_pkg::T_1S;
          t.expire <= (sec_q == mbw_pkg::T_1S);
        end else begin
          cyc_q <= cyc_q + 1'b1;
        end
      end
    end
  end

endmodule

// ==== hw/mbw_top.sv ====
// Purpose: Boot-phase watchdog and three-stage runtime watchdog
// Assumes: Config ports come from same-clock logic and stay steady
// Notes:   Status pins are asynchronous and pass a filtered synchroniser

`timescale 1ns/1ps

// Function
// - Boot watchdog off or 30s to 30m
// - Boot watchdog counts in self-test, resets
// - Optional halt during popup or password
// - Runtime modes off, once, single, repeated
// - Runtime watchdog armed at OS start
// - One-time mode stops on first trigger
// - Single mode runs each stage once
// - Repeated mode reruns final stage forever
// - Programmable start delay before runtime active
// - Stage one action ACPI, reset, button
// - Stages two, three also selectable off
// - Per-stage timeout 1s to 30m
// - ACPI action shutdown or restart
// - Shutdown sent as over-temperature notice
// - Restart sent as ACPI fatal error
// - No non-maskable interrupt action offered
module mbw_top #(
  parameter int unsigned P_CYC_PER_SEC = mbw_pkg::CYC_PER_SEC
) (
  input wire logic i_clk,                // Core clock, 250 MHz
  input wire logic i_rstn,               // Sync reset, active low
  input wire logic i_post_active,        // Self-test running, level
  input wire logic i_user_wait,          // Popup or password wait, level
  input wire logic i_os_start,           // OS boot begins, rising edge
  input wire logic i_kick,               // Software trigger, rising edge
  input wire logic [2:0] i_post_sel,     // Boot watchdog timeout code
  input wire logic i_post_user_stop,     // Halt boot watchdog on user wait
  input wire logic [1:0] i_rt_mode,      // Runtime mode
  input wire logic [2:0] i_rt_delay_sel, // Start delay code
  input wire logic [1:0] i_ev1_sel,      // Stage one action
  input wire logic [1:0] i_ev2_sel,      // Stage two action
  input wire logic [1:0] i_ev3_sel,      // Stage three action
  input wire logic [3:0] i_to1_sel,      // Stage one timeout code
  input wire logic [3:0] i_to2_sel,      // Stage two timeout code
  input wire logic [3:0] i_to3_sel,      // Stage three timeout code
  input wire logic i_acpi_restart,       // ACPI action: 0 shutdown, 1 restart
  output logic o_sys_reset,              // System reset pulse
  output logic o_pwr_btn,                // Power-button event pulse
  output logic o_os_overtemp,            // Over-temperature notice pulse
  output logic o_acpi_fatal,             // ACPI fatal error pulse
  output logic o_post_running,           // Boot watchdog counting
  output logic [1:0] o_rt_state,         // Runtime state code
  output logic [1:0] o_rt_stage          // Current stage index
);

  // ************************************************************
  // Lookup functions
  // ************************************************************
  // Boot watchdog timeout in seconds
  function automatic mbw_pkg::mbw_sec_t post_secs(input logic [2:0] sel);
    case (sel)
      3'h1: post_secs = mbw_pkg::T_30S;
      3'h2: post_secs = mbw_pkg::T_1M;
      3'h3: post_secs = mbw_pkg::T_2M;
      3'h4: post_secs = mbw_pkg::T_5M;
      3'h5: post_secs = mbw_pkg::T_10M;
      3'h6: post_secs = mbw_pkg::T_30M;
      3'h7: post_secs = mbw_pkg::T_30M;
      default: post_secs = mbw_pkg::T_0S;
    endcase
  endfunction

  // Start delay in seconds
  function automatic mbw_pkg::mbw_sec_t delay_secs(input logic [2:0] sel);
    case (sel)
      3'h1: delay_secs = mbw_pkg::T_10S;
      3'h2: delay_secs = mbw_pkg::T_30S;
      3'h3: delay_secs = mbw_pkg::T_1M;
      3'h4: delay_secs = mbw_pkg::T_2M;
      3'h5: delay_secs = mbw_pkg::T_5M;
      3'h6: delay_secs = mbw_pkg::T_10M;
      3'h7: delay_secs = mbw_pkg::T_30M;
      default: delay_secs = mbw_pkg::T_0S;
    endcase
  endfunction

  // Stage timeout in seconds, unknown codes fall back to 30s
  function automatic mbw_pkg::mbw_sec_t stage_secs(input logic [3:0] sel);
    case (sel)
      4'h0: stage_secs = mbw_pkg::T_1S;
      4'h1: stage_secs = mbw_pkg::T_2S;
      4'h2: stage_secs = mbw_pkg::T_5S;
      4'h3: stage_secs = mbw_pkg::T_10S;
      4'h4: stage_secs = mbw_pkg::T_30S;
      4'h5: stage_secs = mbw_pkg::T_1M;
      4'h6: stage_secs = mbw_pkg::T_2M;
      4'h7: stage_secs = mbw_pkg::T_5M;
      4'h8: stage_secs = mbw_pkg::T_10M;
      4'h9: stage_secs = mbw_pkg::T_30M;
      default: stage_secs = mbw_pkg::T_30S;
    endcase
  endfunction

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [mbw_pkg::N_PINS-1:0] pin_raw;
  logic [mbw_pkg::N_PINS-1:0] pin_lvl;
  logic post_lvl;
  logic wait_lvl;
  logic os_lvl;
  logic kick_lvl;

  assign pin_raw = {i_kick, i_os_start, i_user_wait, i_post_active};

  mbw_in_sync #(
    .W(mbw_pkg::N_PINS)
  ) u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d(pin_raw),
    .o_q(pin_lvl)
  );

  assign post_lvl = pin_lvl[0];
  assign wait_lvl = pin_lvl[1];
  assign os_lvl = pin_lvl[2];
  assign kick_lvl = pin_lvl[3];

  // Edge detection on filtered levels
  logic post_prev_q;
  logic os_prev_q;
  logic kick_prev_q;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      post_prev_q <= 1'b0;
      os_prev_q <= 1'b0;
      kick_prev_q <= 1'b0;
    end else begin
      post_prev_q <= post_lvl;
      os_prev_q <= os_lvl;
      kick_prev_q <= kick_lvl;
    end
  end

  logic post_rise;
  logic os_rise;
  logic kick_rise;
  assign post_rise = post_lvl & ~post_prev_q;
  assign os_rise = os_lvl & ~os_prev_q;
  assign kick_rise = kick_lvl & ~kick_prev_q;

  // ************************************************************
  // Boot-phase watchdog
  // ************************************************************
  mbw_tmr_if post_t ();

  mbw_timer #(
    .P_CYC_PER_SEC(P_CYC_PER_SEC)
  ) u_post_tmr (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .t(post_t)
  );

  logic post_en;
  logic post_halt;
  assign post_en = (i_post_sel != mbw_pkg::POST_OFF);
  assign post_halt = i_post_user_stop & wait_lvl;
  assign post_t.load = post_rise & post_en;
  assign post_t.load_val = post_secs(i_post_sel);
  assign post_t.run = post_lvl & post_en & ~post_halt;

  logic post_fire;
  assign post_fire = post_t.expire;

  // ************************************************************
  // Runtime watchdog
  // ************************************************************
  mbw_tmr_if rt_t ();

  mbw_timer #(
    .P_CYC_PER_SEC(P_CYC_PER_SEC)
  ) u_rt_tmr (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .t(rt_t)
  );

  mbw_pkg::mbw_rt_e rt_st_q;
  mbw_pkg::mbw_rt_e rt_st_d;
  logic [1:0] stage_q;
  logic [1:0] stage_d;
  logic rt_load;
  mbw_pkg::mbw_sec_t rt_load_val;
  logic rt_fire;

  // Stage decode shared by the state machine and the action logic
  logic [1:0] ev1_eff;
  logic [1:0] cur_act;
  logic nxt_ok;
  logic [1:0] nxt_stage;
  mbw_pkg::mbw_sec_t to1_secs;
  mbw_pkg::mbw_sec_t cur_secs;
  mbw_pkg::mbw_sec_t nxt_secs;

  assign ev1_eff = (i_ev1_sel == mbw_pkg::ACT_NONE) ? mbw_pkg::ACT_RESET : i_ev1_sel;
  assign cur_act = (stage_q == mbw_pkg::STG_1) ? ev1_eff :
                   (stage_q == mbw_pkg::STG_2) ? i_ev2_sel : i_ev3_sel;
  // A disabled stage ends the chain
  assign nxt_ok = ((stage_q == mbw_pkg::STG_1) && (i_ev2_sel != mbw_pkg::ACT_NONE)) ||
                  ((stage_q == mbw_pkg::STG_2) && (i_ev3_sel != mbw_pkg::ACT_NONE));
  assign nxt_stage = (stage_q == mbw_pkg::STG_1) ? mbw_pkg::STG_2 : mbw_pkg::STG_3;
  assign to1_secs = stage_secs(i_to1_sel);
  assign cur_secs = (stage_q == mbw_pkg::STG_1) ? to1_secs :
                    (stage_q == mbw_pkg::STG_2) ? stage_secs(i_to2_sel) : stage_secs(i_to3_sel);
  assign nxt_secs = (nxt_stage == mbw_pkg::STG_2) ? stage_secs(i_to2_sel) : stage_secs(i_to3_sel);

  // Runtime sequencing; a trigger wins over an expiry in the same cycle
  always_comb begin
    rt_st_d = rt_st_q;
    stage_d = stage_q;
    rt_load = 1'b0;
    rt_load_val = mbw_pkg::T_0S;
    rt_fire = 1'b0;
    case (rt_st_q)
      mbw_pkg::RT_OFF, mbw_pkg::RT_DONE: begin
        if (os_rise && (i_rt_mode != mbw_pkg::MODE_OFF)) begin
          stage_d = mbw_pkg::STG_1;
          rt_load = 1'b1;
          if (i_rt_delay_sel == mbw_pkg::DLY_OFF) begin
            rt_st_d = mbw_pkg::RT_STAGE;
            rt_load_val = to1_secs;
          end else begin
            rt_st_d = mbw_pkg::RT_DELAY;
            rt_load_val = delay_secs(i_rt_delay_sel);
          end
        end
      end
      mbw_pkg::RT_DELAY: begin
        if (rt_t.expire) begin
          rt_st_d = mbw_pkg::RT_STAGE;
          stage_d = mbw_pkg::STG_1;
          rt_load = 1'b1;
          rt_load_val = to1_secs;
        end
      end
      mbw_pkg::RT_STAGE: begin
        if (kick_rise) begin
          if (i_rt_mode == mbw_pkg::MODE_ONCE) begin
            rt_st_d = mbw_pkg::RT_DONE;
          end else begin
            stage_d = mbw_pkg::STG_1;
            rt_load = 1'b1;
            rt_load_val = to1_secs;
          end
        end else if (rt_t.expire) begin
          rt_fire = 1'b1;
          if (nxt_ok) begin
            stage_d = nxt_stage;
            rt_load = 1'b1;
            rt_load_val = nxt_secs;
          end else if (i_rt_mode == mbw_pkg::MODE_REPEAT) begin
            rt_load = 1'b1;
            rt_load_val = cur_secs;
          end else begin
            rt_st_d = mbw_pkg::RT_DONE;
          end
        end
      end
      default: begin
        rt_st_d = mbw_pkg::RT_OFF;
      end
    endcase
    if (i_rt_mode == mbw_pkg::MODE_OFF) begin
      rt_st_d = mbw_pkg::RT_OFF;
      rt_load = 1'b0;
      rt_fire = 1'b0;
    end
  end

  assign rt_t.load = rt_load;
  assign rt_t.load_val = rt_load_val;
  assign rt_t.run = (rt_st_q == mbw_pkg::RT_DELAY) || (rt_st_q == mbw_pkg::RT_STAGE);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rt_st_q <= mbw_pkg::RT_OFF;
      stage_q <= mbw_pkg::STG_1;
    end else begin
      rt_st_q <= rt_st_d;
      stage_q <= stage_d;
    end
  end

  // ************************************************************
  // Action outputs
  // ************************************************************
  logic act_acpi;
  logic reset_d;
  logic pwr_d;
  logic overtemp_d;
  logic fatal_d;

  assign act_acpi = rt_fire && (cur_act == mbw_pkg::ACT_ACPI);
  assign reset_d = post_fire | (rt_fire && (cur_act == mbw_pkg::ACT_RESET));
  assign pwr_d = rt_fire && (cur_act == mbw_pkg::ACT_PWRBTN);
  assign overtemp_d = act_acpi & ~i_acpi_restart;
  assign fatal_d = act_acpi & i_acpi_restart;
  // No NMI output exists
  // Only four action outputs, no interrupt line to the processor

  // Registered so every output comes from a flop
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_sys_reset <= 1'b0;
      o_pwr_btn <= 1'b0;
      o_os_overtemp <= 1'b0;
      o_acpi_fatal <= 1'b0;
      o_post_running <= 1'b0;
      o_rt_state <= 2'h0;
      o_rt_stage <= 2'h0;
    end else begin
      o_sys_reset <= reset_d;
      o_pwr_btn <= pwr_d;
      o_os_overtemp <= overtemp_d;
      o_acpi_fatal <= fatal_d;
      o_post_running <= post_t.run;
      o_rt_state <= rt_st_d;
      o_rt_stage <= stage_d;
    end
  end

endmodule

// ==== sim/mbw_top_properties.sv ====
// Purpose: Concurrent checks on the watchdog top ports
// Assumes: Config ports held steady
// Notes: Spacing check needs eight or more cycles a second

`timescale 1ns/1ps

module mbw_top_properties (
  input wire logic i_clk, // Clock
  input wire logic i_rstn, // Reset
  input wire logic [2:0] i_post_sel, // Boot code
  input wire logic [1:0] i_rt_mode, // Mode
  input wire logic [2:0] i_rt_delay_sel, // Delay code
  input wire logic [1:0] i_ev1_sel, // Action 1
  input wire logic [1:0] i_ev2_sel, // Action 2
  input wire logic [1:0] i_ev3_sel, // Action 3
  input wire logic i_acpi_restart, // ACPI kind
  input wire logic o_sys_reset, // Reset pulse
  input wire logic o_pwr_btn, // Button pulse
  input wire logic o_os_overtemp, // Shutdown pulse
  input wire logic o_acpi_fatal, // Restart pulse
  input wire logic o_post_running, // Boot counting
  input wire logic [1:0] o_rt_state // State
);
  // ************************************************************
  // Checks
  // ************************************************************
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  // Action pulses, runtime only and all
  wire logic rt_act = o_pwr_btn | o_os_overtemp | o_acpi_fatal;
  wire logic any_act = rt_act | o_sys_reset;
  sequence act_s;
    any_act;
  endsequence
  sequence quiet_s;
    !any_act [*8];
  endsequence
  pulse_spacing_a: assert property (act_s |=> quiet_s)
    else $error("action pulses too close");
  shutdown_path_a: assert property (o_os_overtemp |-> !i_acpi_restart)
    else $error("overtemp with restart");
  restart_path_a: assert property (o_acpi_fatal |-> i_acpi_restart)
    else $error("fatal with shutdown");
  button_source_a: assert property (o_pwr_btn |-> (i_ev1_sel == 2'h3 || i_ev2_sel == 2'h3 || i_ev3_sel == 2'h3))
    else $error("button without action");
  acpi_source_a: assert property ((o_os_overtemp || o_acpi_fatal) |->
    (i_ev1_sel == 2'h1 || i_ev2_sel == 2'h1 || i_ev3_sel == 2'h1))
    else $error("ACPI without action");
  mode_off_a: assert property ((i_rt_mode == 2'h0) [*3] |-> (o_rt_state == 2'h0 && !rt_act))
    else $error("active while off");
  boot_sel_a: assert property (o_post_running |-> $past(i_post_sel) != 3'h0)
    else $error("boot counts while off");
  delay_state_a: assert property (o_rt_state == 2'h1 |-> i_rt_delay_sel != 3'h0)
    else $error("delay without code");
  done_quiet_a: assert property ((o_rt_state == 2'h3) [*2] |-> !rt_act)
    else $error("action after done");
  done_entry_a: assert property ($changed(o_rt_state) && o_rt_state == 2'h3 |-> $past(o_rt_state) == 2'h2)
    else $error("done not from staging");
endmodule

bind mbw_top mbw_top_properties u_props (.*);

// ==== sim/mbw_host_model.sv ====
// Purpose: Firmware and OS side driving the status pins
// Assumes: The bench calls one task at a time
// Notes: Each phase is held four cycles, above the filter need

`timescale 1ns/1ps

module mbw_host_model (
  input wire logic i_clk, // Clock
  output logic o_post_active = 1'b0, // Self-test running
  output logic o_user_wait = 1'b0, // Popup or password
  output logic o_os_start = 1'b0, // OS boot begins
  output logic o_kick = 1'b0 // Software trigger
);
  // ************************************************************
  // Pin drivers
  // ************************************************************
  // self-test level
  task automatic set_post(input logic v);
    @(posedge i_clk);
    o_post_active <= v;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic set_wait(input logic v);
    @(posedge i_clk);
    o_user_wait <= v;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic os_boot();
    @(posedge i_clk);
    o_os_start <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_os_start <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic kick();
    @(posedge i_clk);
    o_kick <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_kick <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
endmodule

// ==== sim/mbw_top_tb.sv ====
// Purpose: Self-checking bench for the boot and runtime watchdog
// Assumes: Ten cycles stand for one second
// Notes: Pulse times allow for synchroniser delay

`timescale 1ns/1ps

module mbw_top_tb;
  // ************************************************************
  // Setup
  // ************************************************************
  localparam int unsigned P = 10;
  localparam int LAT = 7;
  localparam int TOL = 5;
  typedef struct {
    logic [3:0] ev;
    int t;
  } mbw_note_s;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [2:0] post_sel = 3'h0;
  logic post_stop = 1'b0;
  logic [1:0] rt_mode = 2'h0;
  logic [2:0] dly_sel = 3'h0;
  logic [5:0] ev_sel = 6'h00;
  logic [11:0] to_sel = 12'h000;
  logic acpi_rst = 1'b0;
  wire logic post_act, user_wait, os_start, kick;
  wire logic sys_rst, pwr_btn, overtemp, fatal, post_run;
  wire logic [1:0] rt_state, rt_stage;
  wire logic [3:0] act = {sys_rst, pwr_btn, overtemp, fatal};
  int cyc = 0;
  int error_cnt = 0;
  int tests_run = 0;
  mbw_note_s notes[$];
  mbw_note_s mon_n;
  int boot_s[7] = '{0, 30, 60, 120, 300, 600, 1800};
  int to_s[11] = '{1, 2, 5, 10, 30, 60, 120, 300, 600, 1800, 30};

  always #2 i_clk = ~i_clk;
  // Cycle count for pulse timing
  always @(posedge i_clk) cyc <= cyc + 1;

  mbw_host_model host (.i_clk, .o_post_active(post_act), .o_user_wait(user_wait),
    .o_os_start(os_start), .o_kick(kick));
  mbw_top #(.P_CYC_PER_SEC(P)) dut (.i_clk, .i_rstn, .i_post_active(post_act),
    .i_user_wait(user_wait), .i_os_start(os_start), .i_kick(kick), .i_post_sel(post_sel),
    .i_post_user_stop(post_stop), .i_rt_mode(rt_mode), .i_rt_delay_sel(dly_sel),
    .i_ev1_sel(ev_sel[1:0]), .i_ev2_sel(ev_sel[3:2]), .i_ev3_sel(ev_sel[5:4]),
    .i_to1_sel(to_sel[3:0]), .i_to2_sel(to_sel[7:4]), .i_to3_sel(to_sel[11:8]),
    .i_acpi_restart(acpi_rst), .o_sys_reset(sys_rst), .o_pwr_btn(pwr_btn),
    .o_os_overtemp(overtemp), .o_acpi_fatal(fatal), .o_post_running(post_run),
    .o_rt_state(rt_state), .o_rt_stage(rt_stage));

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (exp !== got) begin
      error_cnt++;
      $display("mismatch at %0t exp %h got %h", $time, exp, got);
    end
  endtask
  // Expected pulse, timed from now
  task automatic note(input logic [3:0] ev, input int dt);
    mbw_note_s n;
    n.ev = ev;
    n.t = cyc + dt + LAT;
    notes.push_back(n);
  endtask
  // Bounded wait until every note is matched
  task automatic drain(input int max);
    for (int i = 0; i < max && notes.size() > 0; i++) @(posedge i_clk);
    check(32'h0, notes.size());
  endtask
  task automatic wait_state(input logic [1:0] s, input int max);
    for (int i = 0; i < max && rt_state !== s; i++) @(posedge i_clk);
    check(s, rt_state);
  endtask
  task automatic cfg_rt(input logic [1:0] m, input logic [2:0] d, input logic [5:0] ev,
                        input logic [11:0] to, input logic r);
    @(posedge i_clk);
    rt_mode <= m;
    dly_sel <= d;
    ev_sel <= ev;
    to_sel <= to;
    acpi_rst <= r;
  endtask
  task automatic results();
    $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ************************************************************
  // Monitor and watchdog
  // ************************************************************
  // A pulse with no note pending is a mismatch
  always @(negedge i_clk) begin
    if (i_rstn && act !== 4'h0) begin
      if (notes.size() == 0) begin
        check(32'h0, act);
      end else begin
        mon_n = notes.pop_front();
        check(mon_n.ev, act);
        check(mon_n.t, (cyc - mon_n.t <= TOL && mon_n.t - cyc <= TOL) ? mon_n.t : cyc);
      end
    end
  end
  initial begin
    repeat (90000) @(posedge i_clk);
    error_cnt++;
    results();
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    void'($urandom(32'hdccb334c));
    repeat (12) @(posedge i_clk);
    i_rstn <= 1'b1;
    // Boot timeout codes 1 to 6 each end in one reset
    for (int k = 1; k < 7; k++) begin
      @(posedge i_clk);
      post_sel <= k[2:0];
      note(4'h8, boot_s[k] * P);
      host.set_post(1'b1);
      drain(boot_s[k] * P + 40);
      host.set_post(1'b0);
    end
    // Off code and early end stay silent
    @(posedge i_clk);
    post_sel <= 3'h0;
    host.set_post(1'b1);
    repeat (400) @(posedge i_clk);
    check(32'h0, post_run);
    host.set_post(1'b0);
    @(posedge i_clk);
    post_sel <= 3'h1;
    host.set_post(1'b1);
    repeat (200) @(posedge i_clk);
    check(32'h1, post_run);
    host.set_post(1'b0);
    repeat (400) @(posedge i_clk);
    // User wait freezes the boot count
    @(posedge i_clk);
    post_stop <= 1'b1;
    note(4'h8, 500);
    host.set_post(1'b1);
    repeat (100) @(posedge i_clk);
    host.set_wait(1'b1);
    repeat (100) @(posedge i_clk);
    check(32'h0, post_run);
    repeat (96) @(posedge i_clk);
    host.set_wait(1'b0);
    drain(400);
    host.set_post(1'b0);
    // Stage timeout codes 0 to 10 in single mode
    for (int k = 0; k < 11; k++) begin
      post_stop <= 1'($urandom);
      cfg_rt(mbw_pkg::MODE_SINGLE, 3'h0, {4'h0, mbw_pkg::ACT_RESET}, {8'($urandom), k[3:0]}, 1'($urandom));
      note(4'h8, to_s[k] * P);
      host.os_boot();
      drain(to_s[k] * P + 40);
    end
    check(32'h3, rt_state);
    // Three stage chain with a shutdown notice first
    cfg_rt(mbw_pkg::MODE_SINGLE, 3'h0, {mbw_pkg::ACT_PWRBTN, mbw_pkg::ACT_RESET, mbw_pkg::ACT_ACPI}, 12'h210, 1'b0);
    note(4'h2, 10);
    note(4'h8, 32);
    note(4'h4, 84);
    host.os_boot();
    drain(200);
    check(32'h3, rt_state);
    check(32'h2, rt_stage);
    // Repeat mode reruns last stage until reset
    cfg_rt(mbw_pkg::MODE_REPEAT, 3'h0, {mbw_pkg::ACT_NONE, mbw_pkg::ACT_ACPI, mbw_pkg::ACT_PWRBTN}, 12'h000, 1'b1);
    note(4'h4, 10);
    for (int k = 1; k < 4; k++) note(4'h1, 10 + 12 * k);
    host.os_boot();
    drain(100);
    @(posedge i_clk);
    i_rstn <= 1'b0;
    rt_mode <= mbw_pkg::MODE_OFF;
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clk);
    check(32'h0, rt_state);
    // Mode off ignores OS start and triggers
    cfg_rt(mbw_pkg::MODE_OFF, 3'h0, 6'h02, 12'h000, 1'b0);
    host.os_boot();
    host.kick();
    repeat (60) @(posedge i_clk);
    check(32'h0, rt_state);
    // One-time mode stops at the first trigger
    cfg_rt(mbw_pkg::MODE_ONCE, 3'h0, 6'h02, 12'h003, 1'b0);
    repeat (20) @(posedge i_clk);
    check(32'h0, rt_state);
    host.os_boot();
    host.kick();
    repeat (300) @(posedge i_clk);
    check(32'h3, rt_state);
    // Start delay, then random triggers hold off stage one
    cfg_rt(mbw_pkg::MODE_SINGLE, 3'h1, 6'h00, 12'h004, 1'b0);
    host.os_boot();
    host.kick();
    repeat (70) @(posedge i_clk);
    check(32'h1, rt_state);
    wait_state(2'h2, 60);
    for (int k = 0; k < 3; k++) begin
      repeat (150 + $urandom % 100) @(posedge i_clk);
      if (k == 2) note(4'h8, 300);
      host.kick();
    end
    drain(400);
    check(32'h3, rt_state);
    results();
  end
endmodule
